// >>> design/rsf_service_regs.v
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "rsf_defines.vh"
module rsf_service_regs
(
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // wishbone slave
    input  wire       wb_cyc_i,
    input  wire       wb_stb_i,
    input  wire       wb_we_i,
    input  wire [7:0] wb_adr_i,
    input  wire [7:0] wb_dat_i,
    input  wire       wb_sel_i,
    output reg  [7:0] wb_dat_o,
    output reg        wb_ack_o,
    // radio state (same clock domain)
    input  wire [2:0] op_mode_i,
    input  wire       continuous_mode_i,
    input  wire       osc_running_i,
    input  wire       pll_locked_i,
    input  wire       rssi_sampling_i,
    input  wire       pa_ramp_done_i,
    input  wire       rx_settled_i,
    input  wire       calibration_done_i,
    input  wire [7:0] temperature_i,
    input  wire       thermal_drift_i,
    input  wire       strength_over_i,
    input  wire       timeout_i,
    input  wire       preamble_i,
    input  wire       sync_match_i,
    input  wire [6:0] buffer_count_i,
    input  wire [6:0] buffer_level_limit_i,
    input  wire       buffer_overrun_i,
    input  wire       frame_sent_i,
    input  wire       frame_received_i,
    input  wire       checksum_valid_i,
    // supply comparator, asynchronous analog pin
    input  wire       supply_below_i,
    // controls to the analog and radio side
    output reg        auto_calibration_enable_o,
    output reg        calibration_start_o,
    output reg        calibration_in_progress_o,
    output reg  [1:0] thermal_drift_limit_o,
    output reg        thermal_monitor_active_o,
    output reg        supply_detector_enable_o,
    output reg  [2:0] supply_threshold_select_o,
    output reg        buffer_flush_o
);
    // register state
    reg        auto_cal_reg;
    reg        cal_run_reg;
    reg [1:0]  thr_reg;
    reg        mon_off_reg;
    reg        bat_en_reg;
    reg [2:0]  trim_reg;
    reg [7:0]  temp_reg;
    reg [2:0]  mode_reg;
    reg        ready_reg;
    reg        bat_meta_reg;
    reg        bat_sync_reg;
    reg [7:0]  rd_next;
    wire       wr_stb;
    wire       mode_chg;
    wire       in_rx;
    wire       in_tx;
    wire       fifo_empty;
    wire       leave_rx;
    wire       leave_tx;
    wire       w1c_pre;
    wire       w1c_rssi;
    wire       w1c_sync;
    wire       w1c_ovr;
    wire       w1c_bat;
    wire       f_drift;
    wire       f_rssi;
    wire       f_tmo;
    wire       f_pre;
    wire       f_sync;
    wire       f_ovr;
    wire       f_sent;
    wire       f_payld;
    wire       f_crc;
    wire       f_bat;
    wire       ready_cond;
    wire       in_fs;
    wire [7:0] flags1_word;
    wire [7:0] flags2_word;

    // single-cycle ack; write taken on the acking edge
    assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i & ~wb_ack_o;
    assign in_rx = (op_mode_i == `RSF_MODE_RX);
    assign in_tx = (op_mode_i == `RSF_MODE_TX);
    assign in_fs = (op_mode_i == `RSF_MODE_FS);
    assign mode_chg = (op_mode_i != mode_reg);
    assign leave_rx = mode_chg & (mode_reg == `RSF_MODE_RX);
    assign leave_tx = mode_chg & (mode_reg == `RSF_MODE_TX);
    assign fifo_empty = (buffer_count_i == 7'h00);

    // write-one-to-clear strobes; zero bits do nothing
    assign w1c_rssi = wr_stb & (wb_adr_i == `RSF_ADDR_FLAGS1) & wb_dat_i[`RSF_F1_RSSI];
    assign w1c_pre  = wr_stb & (wb_adr_i == `RSF_ADDR_FLAGS1) & wb_dat_i[`RSF_F1_PRE];
    assign w1c_sync = wr_stb & (wb_adr_i == `RSF_ADDR_FLAGS1) & wb_dat_i[`RSF_F1_SYNC]
                      & continuous_mode_i;
    assign w1c_ovr  = wr_stb & (wb_adr_i == `RSF_ADDR_FLAGS2) & wb_dat_i[`RSF_F2_OVR];
    assign w1c_bat  = wr_stb & (wb_adr_i == `RSF_ADDR_FLAGS2) & wb_dat_i[`RSF_F2_SUPPLY_LOW_FLAG];

    // per-mode readiness condition
    assign ready_cond = (op_mode_i == `RSF_MODE_SLEEP) |
                        ((op_mode_i == `RSF_MODE_STDBY) & osc_running_i) |
                        ((op_mode_i == `RSF_MODE_FS) & pll_locked_i) |
                        (in_rx & rssi_sampling_i) |
                        (in_tx & pa_ramp_done_i);

    // drift flag: cleared by the next finished calibration
    rsf_sticky u_drift
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (thermal_drift_i & ~mon_off_reg),
        .clr_i  (calibration_done_i),
        .flag_o (f_drift)
    );

    // signal strength: only counts while receiving
    rsf_sticky u_rssi
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (in_rx & strength_over_i),
        .clr_i  (leave_rx | w1c_rssi),
        .flag_o (f_rssi)
    );

    // timeout: cleared by leaving rx, an empty fifo or a flush
    rsf_sticky u_tmo
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (timeout_i),
        .clr_i  (leave_rx | fifo_empty | w1c_ovr),
        .flag_o (f_tmo)
    );

    // preamble: only software or a flush clears it
    rsf_sticky u_pre
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (preamble_i),
        .clr_i  (w1c_pre | w1c_ovr),
        .flag_o (f_pre)
    );

    // sync match: software clear gated to continuous mode
    rsf_sticky u_sync
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (sync_match_i),
        .clr_i  (leave_rx | fifo_empty | w1c_sync | w1c_ovr),
        .flag_o (f_sync)
    );

    // overrun: sleep masks the event
    rsf_sticky u_ovr
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (buffer_overrun_i & (op_mode_i != `RSF_MODE_SLEEP)),
        .clr_i  (w1c_ovr),
        .flag_o (f_ovr)
    );

    // frame sent: held until transmit is left
    rsf_sticky u_sent
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (in_tx & frame_sent_i),
        .clr_i  (leave_tx),
        .flag_o (f_sent)
    );

    // frame received: survives leaving rx, drops when fifo drains
    rsf_sticky u_payld
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (in_rx & frame_received_i),
        .clr_i  (fifo_empty | w1c_ovr),
        .flag_o (f_payld)
    );

    // checksum good: same lifetime as the frame flag
    rsf_sticky u_crc
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (in_rx & checksum_valid_i),
        .clr_i  (fifo_empty | w1c_ovr),
        .flag_o (f_crc)
    );

    // low supply: sticky until software clears it, even after recovery
    rsf_sticky u_bat
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (bat_sync_reg & bat_en_reg),
        .clr_i  (w1c_bat),
        .flag_o (f_bat)
    );

    // first flag register: live levels gated by mode, then sticky events
    assign flags1_word[`RSF_F1_READY] = ready_reg;
    assign flags1_word[`RSF_F1_RXRDY] = rx_settled_i & in_rx;
    assign flags1_word[`RSF_F1_TXRDY] = pa_ramp_done_i & in_tx;
    assign flags1_word[`RSF_F1_LOCK]  = pll_locked_i & (in_rx | in_tx | in_fs);
    assign flags1_word[`RSF_F1_RSSI]  = f_rssi;
    assign flags1_word[`RSF_F1_TMO]   = f_tmo;
    assign flags1_word[`RSF_F1_PRE]   = f_pre;
    assign flags1_word[`RSF_F1_SYNC]  = f_sync;

    // second flag register: fifo levels are live, the rest sticky
    assign flags2_word[`RSF_F2_FULL]   = (buffer_count_i == `RSF_FIFO_DEPTH);
    assign flags2_word[`RSF_F2_EMPTY]  = fifo_empty;
    assign flags2_word[`RSF_F2_LEVEL]  = (buffer_count_i > buffer_level_limit_i);
    assign flags2_word[`RSF_F2_OVR]    = f_ovr;
    assign flags2_word[`RSF_F2_SENT]   = f_sent;
    assign flags2_word[`RSF_F2_PAYLD]  = f_payld;
    assign flags2_word[`RSF_F2_CRC]    = f_crc;
    assign flags2_word[`RSF_F2_SUPPLY_LOW_FLAG] = f_bat;

    // analog comparator is asynchronous: two-stage synchroniser
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bat_meta_reg <= 1'b0;
            bat_sync_reg <= 1'b0;
        end
        else
        begin
            bat_meta_reg <= supply_below_i;
            bat_sync_reg <= bat_meta_reg;
        end
    end

    // control registers, mode tracking, calibration status
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            auto_cal_reg <= 1'b0;
            cal_run_reg  <= 1'b0;
            thr_reg      <= `RSF_CAL_THR_RST;
            mon_off_reg  <= 1'b0;
            bat_en_reg   <= 1'b0;
            trim_reg     <= `RSF_BAT_TRIM_RST;
            temp_reg     <= 8'h00;
            mode_reg     <= `RSF_MODE_STDBY;
            ready_reg    <= 1'b0;
        end
        else
        begin
            mode_reg <= op_mode_i;
            // change of mode clears ready for at least one cycle
            if (mode_chg)
                ready_reg <= 1'b0;
            else if (ready_cond)
                ready_reg <= 1'b1;
            // temperature only refreshed while the monitor runs
            if (~mon_off_reg & (op_mode_i != `RSF_MODE_SLEEP) &
                (op_mode_i != `RSF_MODE_STDBY))
                temp_reg <= temperature_i;
            if (wr_stb & (wb_adr_i == `RSF_ADDR_CAL))
            begin
                auto_cal_reg <= wb_dat_i[`RSF_CAL_AUTO_BIT];
                thr_reg      <= wb_dat_i[2:1];
                mon_off_reg  <= wb_dat_i[`RSF_CAL_MONOFF_BIT];
            end
            if (wr_stb & (wb_adr_i == `RSF_ADDR_BAT))
            begin
                bat_en_reg <= wb_dat_i[`RSF_BAT_EN_BIT];
                trim_reg   <= wb_dat_i[2:0];
            end
            // running from trigger until done; a fresh start beats a stale done
            if (calibration_start_o)
                cal_run_reg <= 1'b1;
            else if (calibration_done_i)
                cal_run_reg <= 1'b0;
        end
    end

    // read multiplexer; unmapped reads return zero
    always @*
    begin
        rd_next = 8'h00;
        case (wb_adr_i)
            `RSF_ADDR_CAL:
                rd_next = {auto_cal_reg, 1'b0, cal_run_reg, 1'b0, f_drift,
                           thr_reg, mon_off_reg};
            `RSF_ADDR_TEMP:
                rd_next = temp_reg;
            `RSF_ADDR_BAT:
                rd_next = {4'h0, bat_en_reg, trim_reg};
            `RSF_ADDR_FLAGS1:
                rd_next = flags1_word;
            `RSF_ADDR_FLAGS2:
                rd_next = flags2_word;
            default:
                rd_next = 8'h00;
        endcase
    end

    // bus answer and registered outputs
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o                  <= 1'b0;
            wb_dat_o                  <= 8'h00;
            calibration_start_o       <= 1'b0;
            buffer_flush_o            <= 1'b0;
            auto_calibration_enable_o <= 1'b0;
            calibration_in_progress_o <= 1'b0;
            thermal_drift_limit_o     <= `RSF_CAL_THR_RST;
            thermal_monitor_active_o  <= 1'b0;
            supply_detector_enable_o  <= 1'b0;
            supply_threshold_select_o <= `RSF_BAT_TRIM_RST;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= rd_next;
            // trigger only accepted in standby; never stored
            calibration_start_o <= wr_stb & (wb_adr_i == `RSF_ADDR_CAL) &
                                   wb_dat_i[`RSF_CAL_START_BIT] &
                                   (op_mode_i == `RSF_MODE_STDBY) & ~cal_run_reg;
            buffer_flush_o <= w1c_ovr;
            auto_calibration_enable_o <= auto_cal_reg;
            calibration_in_progress_o <= cal_run_reg;
            thermal_drift_limit_o     <= thr_reg;
            thermal_monitor_active_o  <= ~mon_off_reg & (op_mode_i != `RSF_MODE_SLEEP) &
                                         (op_mode_i != `RSF_MODE_STDBY);
            supply_detector_enable_o  <= bat_en_reg;
            supply_threshold_select_o <= trim_reg;
        end
    end
endmodule

// >>> inc/rsf_defines.vh
// Operation
// - bit7 enables temperature-driven image calibration
// - write one bit6 in standby starts calibration
// - bit5 reads one while calibration runs
// - bit3 flags temperature drift beyond threshold
// - threshold field selects 5/10/15/20 degrees
// - bit0 one stops temperature monitoring
// - temperature register reads minus one degree per lsb
// - battery bit3 enables low-battery detector
// - trim field selects eight thresholds, reset 2
// - mode-ready sets when reached, clears on change
// - rx/tx settled flags set, clear leaving mode
// - lock flag follows pll lock in fs/rx/tx
// - strength flag sets in rx, w1c or leave
// - timeout flag clears leaving rx or empty
// - preamble flag set on detect, w1c
// - sync flag w1c only in continuous mode
// - full at 66 bytes, empty at zero
// - level flag when count exceeds limit
// - overrun flag w1c flushes fifo and flags
// - sent flag sets in tx, clears leaving tx
// - payload and crc flags clear on empty
// - low-battery flag sticky until w1c
`ifndef RSF_DEFINES_VH
`define RSF_DEFINES_VH
`define RSF_ADDR_CAL      8'h3b
`define RSF_ADDR_TEMP     8'h3c
`define RSF_ADDR_BAT      8'h3d
`define RSF_ADDR_FLAGS1   8'h3e
`define RSF_ADDR_FLAGS2   8'h3f
`define RSF_CAL_AUTO_BIT  7
`define RSF_CAL_START_BIT 6
`define RSF_CAL_RUN_BIT   5
`define RSF_CAL_DRIFT_BIT 3
`define RSF_CAL_MONOFF_BIT 0
`define RSF_CAL_THR_RST   2'h1
`define RSF_BAT_EN_BIT    3
`define RSF_BAT_TRIM_RST  3'h2
`define RSF_F1_READY      7
`define RSF_F1_RXRDY      6
`define RSF_F1_TXRDY      5
`define RSF_F1_LOCK       4
`define RSF_F1_RSSI       3
`define RSF_F1_TMO        2
`define RSF_F1_PRE        1
`define RSF_F1_SYNC       0
`define RSF_F2_FULL       7
`define RSF_F2_EMPTY      6
`define RSF_F2_LEVEL      5
`define RSF_F2_OVR        4
`define RSF_F2_SENT       3
`define RSF_F2_PAYLD      2
`define RSF_F2_CRC        1
`define RSF_F2_SUPPLY_LOW_FLAG     0
`define RSF_FIFO_DEPTH    7'h42
`define RSF_MODE_SLEEP    3'h0
`define RSF_MODE_STDBY    3'h1
`define RSF_MODE_FS       3'h2
`define RSF_MODE_TX       3'h3
`define RSF_MODE_RX       3'h5
`endif

// >>> design/rsf_sticky.v
`timescale 1ns/10ps
// one sticky event flag: set beats clear
module rsf_sticky
(
    // clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // set and clear
    input  wire set_i,
    input  wire clr_i,
    // flag
    output reg  flag_o
);
    // set has priority so an event in the clear cycle is kept
    always @(posedge clk_i)
    begin
        if (rst_i)
            flag_o <= 1'b0;
        else if (set_i)
            flag_o <= 1'b1;
        else if (clr_i)
            flag_o <= 1'b0;
    end
endmodule

// >>> test/rsf_service_regs_props.sv
`timescale 1ns/10ps
module rsf_props
(
    // clock and reset
    input logic       clk_i,
    input logic       rst_i,
    // bus
    input logic       wb_cyc_i,
    input logic       wb_stb_i,
    input logic       wb_we_i,
    input logic       wb_sel_i,
    input logic [7:0] wb_adr_i,
    input logic [7:0] wb_dat_i,
    input logic [7:0] wb_dat_o,
    input logic       wb_ack_o,
    // state and controls
    input logic [2:0] op_mode_i,
    input logic [6:0] buffer_count_i,
    input logic [6:0] buffer_level_limit_i,
    input logic       auto_calibration_enable_o,
    input logic       calibration_start_o,
    input logic       buffer_flush_o,
    input logic [1:0] thermal_drift_limit_o,
    input logic [2:0] supply_threshold_select_o
);
    default clocking rsf_cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // request taken at this edge
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(a);
        s_req ##0 (wb_we_i && wb_sel_i && wb_adr_i == a);
    endsequence
    // fifo inputs held steady, so the flag registers have caught up
    sequence s_rd2;
        s_req ##0 (!wb_we_i && wb_adr_i == 8'h3f && !$past(rst_i)
            && $stable(buffer_count_i) && $stable(buffer_level_limit_i));
    endsequence
    AST_ACK_ONE: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not one pulse one cycle after the request");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    AST_UNMAPPED: assert property (s_req ##0 (!wb_we_i && (wb_adr_i < 8'h3b ||
        wb_adr_i > 8'h3f)) |=> wb_dat_o == 8'h00) else $error("unmapped read not zero");
    AST_AUTO_CAL: assert property (s_wr(8'h3b) |=> ##1
        auto_calibration_enable_o == $past(wb_dat_i[7], 2))
        else $error("auto calibration enable does not follow the write");
    AST_START: assert property (calibration_start_o |-> $past(wb_we_i && wb_sel_i &&
        wb_adr_i == 8'h3b && wb_dat_i[6] && op_mode_i == 3'h1)) else $error("stray start");
    AST_FLUSH: assert property (buffer_flush_o |-> $past(wb_we_i && wb_sel_i &&
        wb_adr_i == 8'h3f && wb_dat_i[4])) else $error("stray flush");
    AST_FIFO: assert property (s_rd2 |=> wb_dat_o[7:5] == {$past(buffer_count_i) == 7'h42,
        $past(buffer_count_i) == 7'h00, $past(buffer_count_i) > $past(buffer_level_limit_i)})
        else $error("fifo flags wrong");
    AST_RST: assert property ($fell(rst_i) |-> supply_threshold_select_o == 3'h2 &&
        thermal_drift_limit_o == 2'h1) else $error("reset values wrong");
endmodule
bind rsf_service_regs rsf_props u_props
(
    .clk_i                     (clk_i),
    .rst_i                     (rst_i),
    .wb_cyc_i                  (wb_cyc_i),
    .wb_stb_i                  (wb_stb_i),
    .wb_we_i                   (wb_we_i),
    .wb_sel_i                  (wb_sel_i),
    .wb_adr_i                  (wb_adr_i),
    .wb_dat_i                  (wb_dat_i),
    .wb_dat_o                  (wb_dat_o),
    .wb_ack_o                  (wb_ack_o),
    .op_mode_i                 (op_mode_i),
    .buffer_count_i            (buffer_count_i),
    .buffer_level_limit_i      (buffer_level_limit_i),
    .auto_calibration_enable_o (auto_calibration_enable_o),
    .calibration_start_o       (calibration_start_o),
    .buffer_flush_o            (buffer_flush_o),
    .thermal_drift_limit_o     (thermal_drift_limit_o),
    .supply_threshold_select_o (supply_threshold_select_o)
);

// >>> test/test_radio_service_and_irq_flags.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin err_count++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module test_radio_service_and_irq_flags;
    // mode, count, limit, temperature, address, expected read
    typedef struct packed {logic [2:0] m; logic [6:0] c; logic [6:0] l; logic [7:0] t;
        logic [7:0] a; logic [7:0] e;} rsf_row_t;
    // mode, event line, address, bit, mode after, bit after
    typedef struct packed {logic [2:0] m; logic [3:0] k; logic [7:0] a; logic [2:0] b;
        logic [2:0] m2; logic e2;} rsf_ev_t;
    rsf_row_t   rows [8];
    rsf_ev_t    evs [11];
    logic       clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_ack_o, cont, cal_done;
    logic       drift, ovr, below, auto_en, cal_start, cal_run, mon_act, det_en, flush;
    logic [7:0] wb_adr_i, wb_dat_i, wb_dat_o, temp, rd;
    logic [2:0] op_mode_i, trim;
    logic [6:0] cnt, lim;
    logic [1:0] drift_lim;
    logic [10:0] ev;
    int         err_count, checks_done, i;
    rsf_service_regs uut
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_mode_i(op_mode_i),
        .continuous_mode_i(cont), .osc_running_i(ev[10]), .pll_locked_i(ev[9]),
        .rssi_sampling_i(ev[7]), .pa_ramp_done_i(ev[8]), .rx_settled_i(ev[7]),
        .calibration_done_i(cal_done), .temperature_i(temp), .thermal_drift_i(drift),
        .strength_over_i(ev[0]), .timeout_i(ev[1]), .preamble_i(ev[2]), .sync_match_i(ev[3]),
        .buffer_count_i(cnt), .buffer_level_limit_i(lim), .buffer_overrun_i(ovr),
        .frame_sent_i(ev[4]), .frame_received_i(ev[5]), .checksum_valid_i(ev[6]),
        .supply_below_i(below), .auto_calibration_enable_o(auto_en),
        .calibration_start_o(cal_start), .calibration_in_progress_o(cal_run),
        .thermal_drift_limit_o(drift_lim), .thermal_monitor_active_o(mon_act),
        .supply_detector_enable_o(det_en), .supply_threshold_select_o(trim),
        .buffer_flush_o(flush)
    );
    // 100 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled, bounded wait
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 20)
        begin
            err_count++;
            results();
        end
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        `CHK("read", e, rd)
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    initial
    begin
        rows = '{'{3'h2, 7'h00, 7'h0a, 8'h5a, 8'h3c, 8'h5a}, '{3'h2, 7'h05, 7'h0a, 8'ha5, 8'h3c, 8'ha5},
            '{3'h2, 7'h00, 7'h0a, 8'ha5, 8'h3f, 8'h40}, '{3'h2, 7'h42, 7'h0a, 8'ha5, 8'h3f, 8'ha0},
            '{3'h2, 7'h0a, 7'h0a, 8'ha5, 8'h3f, 8'h00}, '{3'h2, 7'h0b, 7'h0a, 8'ha5, 8'h3f, 8'h20},
            '{3'h2, 7'h41, 7'h41, 8'ha5, 8'h3f, 8'h00}, '{3'h2, 7'h01, 7'h00, 8'ha5, 8'h3f, 8'h20}};
        evs = '{'{3'h1, 4'ha, 8'h3e, 3'h7, 3'h2, 1'b0}, '{3'h5, 4'h0, 8'h3e, 3'h3, 3'h1, 1'b0},
            '{3'h5, 4'h1, 8'h3e, 3'h2, 3'h1, 1'b0}, '{3'h5, 4'h2, 8'h3e, 3'h1, 3'h1, 1'b1},
            '{3'h5, 4'h3, 8'h3e, 3'h0, 3'h1, 1'b0}, '{3'h3, 4'h4, 8'h3f, 3'h3, 3'h1, 1'b0},
            '{3'h5, 4'h5, 8'h3f, 3'h2, 3'h1, 1'b1}, '{3'h5, 4'h6, 8'h3f, 3'h1, 3'h1, 1'b1},
            '{3'h5, 4'h7, 8'h3e, 3'h6, 3'h1, 1'b0}, '{3'h3, 4'h8, 8'h3e, 3'h5, 3'h1, 1'b0},
            '{3'h2, 4'h9, 8'h3e, 3'h4, 3'h1, 1'b0}};
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, ev, cont, cal_done} = '0;
        {drift, ovr, below, temp, cnt, lim, err_count, checks_done} = '0;
        {wb_sel_i, rst_i, op_mode_i} = {2'b11, 3'h1};
        tick(10);
        rst_i <= 1'b0;
        rc(8'h3b, 8'h02);
        rc(8'h3d, 8'h02);
        foreach (rows[i])
        begin
            {op_mode_i, cnt, lim, temp} <= {rows[i].m, rows[i].c, rows[i].l, rows[i].t};
            tick(3);
            rc(rows[i].a, rows[i].e);
        end
        // fifo not empty, so the payload and crc flags stay after leaving the mode
        cnt <= 7'h05;
        foreach (evs[i])
        begin
            {op_mode_i, ev} <= {evs[i].m, 11'h001 << evs[i].k};
            tick(4);
            wb(1'b0, evs[i].a, 8'h00);
            `CHK("event set", 1'b1, rd[evs[i].b])
            {op_mode_i, ev} <= {evs[i].m2, 11'h000};
            tick(4);
            wb(1'b0, evs[i].a, 8'h00);
            `CHK("after leave", evs[i].e2, rd[evs[i].b])
        end
        // sync write-one ignored in packet mode, honoured in continuous mode
        {op_mode_i, ev} <= {3'h5, 11'h008};
        tick(2);
        ev <= 11'h000;
        wb(1'b1, 8'h3e, 8'h01);
        wb(1'b0, 8'h3e, 8'h00);
        `CHK("sync packet", 2'b11, rd[1:0])
        cont <= 1'b1;
        wb(1'b1, 8'h3e, 8'h03);
        wb(1'b0, 8'h3e, 8'h00);
        `CHK("w1c", 2'b00, rd[1:0])
        // overrun clear flushes and drops the receive flags too
        {ev, ovr} <= {11'h064, 1'b1};
        tick(2);
        {ev, ovr} <= '0;
        wb(1'b0, 8'h3f, 8'h00);
        `CHK("overrun", 3'b111, {rd[4], rd[2:1]})
        wb(1'b1, 8'h3f, 8'h10);
        `CHK("flush", 1'b1, flush)
        wb(1'b0, 8'h3f, 8'h00);
        `CHK("flushed", 3'b000, {rd[4], rd[2:1]})
        // supply detector latch, sel low write dropped, unmapped space
        wb(1'b1, 8'h3d, 8'h0f);
        // control outputs trail the register by one cycle
        tick(1);
        `CHK("detector", 4'hf, {det_en, trim})
        below <= 1'b1;
        tick(4);
        below <= 1'b0;
        tick(4);
        wb(1'b1, 8'h3f, 8'h00);
        wb(1'b0, 8'h3f, 8'h00);
        `CHK("low supply", 1'b1, rd[0])
        wb(1'b1, 8'h3f, 8'h01);
        wb(1'b0, 8'h3f, 8'h00);
        `CHK("low cleared", 1'b0, rd[0])
        wb_sel_i <= 1'b0;
        wb(1'b1, 8'h3d, 8'h00);
        wb_sel_i <= 1'b1;
        rc(8'h3d, 8'h0f);
        wb(1'b1, 8'h40, 8'hff);
        rc(8'h40, 8'h00);
        // every threshold code, auto enable and monitor stop
        op_mode_i <= 3'h1;
        for (i = 0; i < 4; i++)
        begin
            wb(1'b1, 8'h3b, {i[0], 4'h0, i[1:0], i[1]});
            rc(8'h3b, {i[0], 4'h0, i[1:0], i[1]});
            `CHK("limit", {i[0], i[1:0]}, {auto_en, drift_lim})
        end
        // monitor stopped: temperature frozen
        {op_mode_i, temp} <= {3'h2, 8'h33};
        tick(3);
        rc(8'h3c, 8'ha5);
        `CHK("monitor", 1'b0, mon_act)
        // trigger refused outside standby, then runs until done
        wb(1'b1, 8'h3b, 8'h40);
        `CHK("no start", 1'b0, cal_run)
        tick(1);
        `CHK("monitor on", 1'b1, mon_act)
        {op_mode_i, drift} <= {3'h1, 1'b1};
        tick(2);
        drift <= 1'b0;
        wb(1'b1, 8'h3b, 8'h40);
        `CHK("start", 1'b1, cal_start)
        rc(8'h3b, 8'h28);
        `CHK("running", 1'b1, cal_run)
        cal_done <= 1'b1;
        tick(1);
        cal_done <= 1'b0;
        rc(8'h3b, 8'h00);
        `CHK("done", 1'b0, cal_run)
        // reset again after calibration is done: registers and outputs back to reset values
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        rc(8'h3b, 8'h02);
        `CHK("reset out", 4'h2, {det_en, trim})
        results();
    end
endmodule
